//--- testbench/acrb_config_bank_asserts.sv
`timescale 1ns/100ps
module acrb_config_bank_asserts (
    // Clock and reset
    input wire        core_clk,
    input wire        rst_n,
    // Serial pins
    input wire        cs_n,
    input wire        dout_oe_q,
    // Decoded controls
    input wire [2:0]  pos_input_q,
    input wire [2:0]  neg_input_q,
    input wire        ref_monitor_q,
    input wire [7:0]  gain_q,
    input wire        amp_enable_q,
    input wire [1:0]  op_mode_q,
    input wire        thermal_sense_q,
    input wire [15:0] rate_centi_sps_q,
    input wire        config_fault_q,
    input wire        restart_q
);
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_gain_onehot: assert property ($onehot(gain_q))
        else $error("gain not a power of two");
    a_bypass_gain: assert property (!amp_enable_q |-> ref_monitor_q || gain_q <= 8'h04)
        else $error("amplifier off at high gain");
    a_thermal_force: assert property (thermal_sense_q |-> pos_input_q == 3'h7
        && neg_input_q == 3'h7 && gain_q == 8'h01 && amp_enable_q)
        else $error("thermal mode not overriding inputs");
    a_ref_monitor: assert property (ref_monitor_q && !thermal_sense_q |-> !amp_enable_q)
        else $error("monitor without bypass");
    a_restart_pulse: assert property (restart_q |=> !restart_q)
        else $error("restart longer than one cycle");
    // Settings may only move while a frame is open
    a_idle_stable: assert property (cs_n [*8] |-> $stable(gain_q) && $stable(op_mode_q)
        && $stable(pos_input_q) && $stable(rate_centi_sps_q) && !restart_q)
        else $error("settings moved while deselected");
    a_oe_idle: assert property (cs_n [*7] |-> !dout_oe_q)
        else $error("output driven while deselected");
    a_oe_frame: assert property (!cs_n [*7] |-> dout_oe_q)
        else $error("output not driven in frame");
    a_mode_rsvd: assert property (op_mode_q == 2'h3 |-> config_fault_q)
        else $error("reserved mode not flagged");
    a_reset_dflt: assert property ($rose(rst_n) |-> gain_q == 8'h01 && amp_enable_q
        && pos_input_q == 3'h0 && neg_input_q == 3'h1 && op_mode_q == 2'h0)
        else $error("wrong values after reset");
endmodule // acrb_config_bank_asserts

//--- testbench/acrb_host_model.sv
`timescale 1ns/100ps
// Host side of the mode-1 serial link
module acrb_host_model #(
    parameter HALF = 8
) (
    // Clock
    input  wire core_clk,
    // Serial pins
    output reg  cs_n,
    output reg  sclk,
    output reg  din,
    input  wire dout_q
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din  = 1'b1;
    end
    // Idle data toggles so a stale bit never passes for a driven one
    always @(posedge core_clk) if (cs_n) din <= #1 ~din;
    task automatic wait_clk(input integer n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Launch on rising, sample on falling, MSB first
    task automatic frame(input integer n, input [31:0] tx, output [31:0] rx);
        integer k;
        integer i;
        rx = 32'h0000_0000;
        cs_n = 1'b0;
        wait_clk(HALF);
        for (k = 0; k < n; k = k + 1) begin
            for (i = 31 - 8 * k; i > 23 - 8 * k; i = i - 1) begin
                sclk = 1'b1;
                din  = tx[i];
                wait_clk(HALF);
                rx[i] = dout_q;
                sclk = 1'b0;
                wait_clk(HALF);
            end
        end
        din = ~din;
        wait_clk(HALF);
        cs_n = 1'b1;
        wait_clk(2 * HALF);
    endtask
endmodule // acrb_host_model

//--- testbench/adc_config_register_bank_tb.sv
`timescale 1ns/100ps
`include "acrb_regs.vh"
bind acrb_config_bank acrb_config_bank_asserts acrb_config_bank_asserts_inst (
    .core_clk, .rst_n, .cs_n, .dout_oe_q, .pos_input_q, .neg_input_q, .ref_monitor_q,
    .gain_q, .amp_enable_q, .op_mode_q, .thermal_sense_q, .rate_centi_sps_q,
    .config_fault_q, .restart_q);
module adc_config_register_bank_tb;
    reg         core_clk, rst_n;
    wire        cs_n, sclk, din, dout_q, dout_oe_q, ref_monitor_q, mid_short_q, amp_enable_q;
    wire        continuous_q, thermal_sense_q, fault_current_q, config_fault_q;
    wire        low_side_switch_q, restart_q;
    wire [2:0]  pos_input_q, neg_input_q, excitation_current_q;
    wire [1:0]  op_mode_q, ref_select_q, filter_select_q;
    wire [7:0]  gain_q;
    wire [15:0] rate_centi_sps_q;
    integer     fail_count = 0, comparisons = 0, restarts = 0, i, m, r, r0;
    reg  [31:0] rx;
    reg  [7:0]  v1, v2;
    // Expected {positive, negative}; codes 4 and 5 are not compared
    localparam [71:0] IN_TABLE = {6'h1C, 6'h14, 6'h0C, 6'h04, 6'h1A, 6'h08, 12'h000,
        6'h0A, 6'h03, 6'h02, 6'h01};
    // Rate times 100 by mode and code; turbo 100 and 101 overflow 16 bits, skipped
    localparam [287:0] RATE_TABLE = {32'h0000_0000, 16'h88B8, 16'h4650, 16'h2328, 16'h0FA0,
        16'h3A98, 16'h203A, 16'h1130, 16'h08CA, 16'h0465, 16'h01F4,
        16'hEA60, 16'h80E8, 16'h445C, 16'h2328, 16'h1194, 16'h07D0};
    acrb_config_bank acrb_config_bank_inst (
        .core_clk, .rst_n, .cs_n, .sclk, .din, .dout_q, .dout_oe_q, .pos_input_q,
        .neg_input_q, .ref_monitor_q, .mid_short_q, .gain_q, .amp_enable_q, .op_mode_q,
        .continuous_q, .thermal_sense_q, .fault_current_q, .rate_centi_sps_q,
        .config_fault_q, .ref_select_q, .filter_select_q, .low_side_switch_q,
        .excitation_current_q, .restart_q);
    acrb_host_model acrb_host_model_inst (.core_clk, .cs_n, .sclk, .din, .dout_q);
    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) if (restart_q === 1'b1) restarts <= restarts + 1;
    task automatic chk(input string what, input [31:0] seen, input [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("BAD %0s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input [1:0] idx, input [7:0] v);
        r0 = restarts;
        acrb_host_model_inst.frame(2, {`ACRB_OP_WR, idx, 2'h0, v, 16'h0000}, rx);
        chk("restart", restarts - r0, 1);
    endtask
    task automatic t_reset;
        chk("gain amp inputs", {gain_q, amp_enable_q, pos_input_q, neg_input_q}, 15'h00C1);
        chk("second reg", {op_mode_q, continuous_q, thermal_sense_q, fault_current_q}, 0);
        chk("rate", rate_centi_sps_q, 16'h07D0);
        chk("third reg", {ref_select_q, filter_select_q, excitation_current_q}, 0);
        acrb_host_model_inst.frame(4, {`ACRB_OP_RD, `ACRB_IDX_INPUT_GAIN, 2'h2, 24'h00_0000}, rx);
        chk("readback", rx[23:0], 24'h00_0000);
        $display("reset done");
    endtask
    task automatic t_gain;
        for (i = 0; i < 8; i = i + 1) begin
            wr(`ACRB_IDX_INPUT_GAIN, {4'h0, i[2:0], 1'b1});
            chk("gain", gain_q, 8'h01 << i);
            chk("amp", amp_enable_q, i > 2);
        end
        $display("gain done");
    endtask
    task automatic t_inputs;
        for (i = 0; i < 14; i = i + 1) begin
            if (i != 4 && i != 5) begin
                wr(`ACRB_IDX_INPUT_GAIN, {i[3:0], 4'h5});
                if (i < 12) chk("inputs", {pos_input_q, neg_input_q}, IN_TABLE[6*i +: 6]);
                chk("monitor short", {ref_monitor_q, mid_short_q}, {i == 12, i == 13});
                chk("fault", config_fault_q, 1'b0);
            end
        end
        wr(`ACRB_IDX_INPUT_GAIN, 8'h80);
        chk("ground unbypassed", config_fault_q, 1'b1);
        $display("inputs done");
    endtask
    task automatic t_rates;
        for (m = 0; m < 3; m = m + 1) begin
            for (r = 0; r < 6; r = r + 1) begin
                if (m < 2 || r < 4) begin
                    v1 = {r[2:0], m[1:0], r[0], 1'b0, m[0]};
                    v2 = {m[1:0], r[1:0], r[0], r[2:0]};
                    r0 = restarts;
                    acrb_host_model_inst.frame(3, {`ACRB_OP_WR, 4'h5, v1, v2, 8'h00}, rx);
                    chk("one restart", restarts - r0, 1);
                    chk("rate", rate_centi_sps_q, RATE_TABLE[16*(6*m+r) +: 16]);
                    chk("mode", {op_mode_q, continuous_q, thermal_sense_q, fault_current_q},
                        v1[4:0]);
                    chk("third", {ref_select_q, filter_select_q, low_side_switch_q,
                        excitation_current_q}, v2);
                    acrb_host_model_inst.frame(3, {`ACRB_OP_RD, 4'h5, 24'h00_0000}, rx);
                    chk("readback", rx[23:8], {v1, v2});
                end
            end
        end
        $display("rates done");
    endtask
    task automatic t_special;
        wr(`ACRB_IDX_RATE_MODE, 8'h18);
        chk("mode rsvd", config_fault_q, 1'b1);
        wr(`ACRB_IDX_RATE_MODE, 8'hE0);
        chk("rate rsvd", {config_fault_q, rate_centi_sps_q}, 17'h1_0000);
        wr(`ACRB_IDX_INPUT_GAIN, 8'h36);
        wr(`ACRB_IDX_RATE_MODE, 8'h02);
        chk("thermal", {thermal_sense_q, pos_input_q, neg_input_q, gain_q, amp_enable_q},
            16'hFE03);
        wr(`ACRB_IDX_RATE_MODE, 8'h00);
        chk("thermal off", {pos_input_q, neg_input_q, gain_q}, 14'h0A08);
        $display("special done");
    endtask
    initial begin
        repeat (100000) @(posedge core_clk);
        fail_count = fail_count + 1;
        report_and_stop;
    end
    initial begin
        rst_n = 1'b0;
        repeat (3) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (5) @(posedge core_clk);
        #1;
        t_reset;
        t_gain;
        t_inputs;
        t_rates;
        t_special;
        report_and_stop;
    end
endmodule // adc_config_register_bank_tb

//--- verilog/acrb_config_bank.v
`timescale 1ns/100ps
// Function
// - Input field picks positive and negative inputs
// - Code 1100 monitors reference over four
// - Gain codes map to gains 1 to 128
// - Bypass honoured only at gains 1, 2, 4
// - Rate field meaning depends on mode
// - Mode field selects normal, duty, turbo
// - Continuity bit selects single or continuous
// - Thermal sense overrides whole first register
// - Fault bit switches burn-out sources
// - Rate codes give per-mode sample rates
// - Rates scale with device clock frequency
// - Third register holds reference, filter, switch, current
// - Second register resets to zero
// - First register resets to zero
// - Access only through serial read, write commands
// - Commit on last falling edge, restart conversion
`include "acrb_regs.vh"
module acrb_config_bank #(
    parameter CLK_KHZ = `ACRB_REF_CLK_KHZ
) (
    // Clock and reset
    input  wire       core_clk,
    input  wire       rst_n,
    // Serial pins, mode 1
    input  wire       cs_n,
    input  wire       sclk,
    input  wire       din,
    output reg        dout_q,
    output reg        dout_oe_q,
    // Decoded analog controls
    output reg  [2:0] pos_input_q,
    output reg  [2:0] neg_input_q,
    output reg        ref_monitor_q,
    output reg        mid_short_q,
    output reg  [7:0] gain_q,
    output reg        amp_enable_q,
    output reg  [1:0] op_mode_q,
    output reg        continuous_q,
    output reg        thermal_sense_q,
    output reg        fault_current_q,
    output reg [15:0] rate_centi_sps_q,
    output reg        config_fault_q,
    output reg  [1:0] ref_select_q,
    output reg  [1:0] filter_select_q,
    output reg        low_side_switch_q,
    output reg  [2:0] excitation_current_q,
    output reg        restart_q
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    wire cs_lvl;
    wire sclk_rise;
    wire sclk_fall;
    wire din_lvl;
    wire cs_rise_unused;
    wire cs_fall_unused;
    wire din_rise_unused;
    wire din_fall_unused;
    wire sclk_lvl_unused;
    // Select is synchronised active high so its reset level matches the idle pin
    acrb_serial_sync u_cs (.core_clk(core_clk), .rst_n(rst_n), .pin_in(~cs_n),
        .level_q(cs_lvl), .rise_q(cs_rise_unused), .fall_q(cs_fall_unused));
    acrb_serial_sync u_sclk (.core_clk(core_clk), .rst_n(rst_n), .pin_in(sclk),
        .level_q(sclk_lvl_unused), .rise_q(sclk_rise), .fall_q(sclk_fall));
    acrb_serial_sync u_din (.core_clk(core_clk), .rst_n(rst_n), .pin_in(din),
        .level_q(din_lvl), .rise_q(din_rise_unused), .fall_q(din_fall_unused));

    ////////////////////////////////////////////////////////////////////////
    // Register storage, indexed flip-flops
    reg [7:0] regs_q [0:3];

    // Rate table in centi-samples per second at the nominal clock
    function [15:0] rate_nominal;
        input [1:0] mode;
        input [2:0] code;
        reg   [15:0] base;
        begin
            case (code)
                3'h0:    base = 16'h07D0;
                3'h1:    base = 16'h1194;
                3'h2:    base = 16'h2328;
                3'h3:    base = 16'h445C;
                3'h4:    base = 16'h80E8;
                3'h5:    base = 16'hEA60;
                default: base = 16'h0000;
            endcase
            if (code == 3'h6) begin
                base = 16'h0000;
            end
            case (mode)
                // Code 011 in duty mode is 44 SPS, not a quarter of 175
                `ACRB_MODE_DUTY:  rate_nominal = (code == 3'h3) ? 16'h1130 : (base >> 2);
                `ACRB_MODE_TURBO: rate_nominal = base << 1;
                default:          rate_nominal = base;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Serial command engine, one-hot
    localparam ST_CMD  = 4'b0001;
    localparam ST_WR   = 4'b0010;
    localparam ST_RD   = 4'b0100;
    localparam ST_SKIP = 4'b1000;

    reg [3:0] state_q;
    reg [2:0] bit_q;
    reg [7:0] sh_q;
    reg [1:0] addr_q;
    reg [1:0] left_q;
    reg [7:0] tx_q;
    wire [7:0] sh_next = {sh_q[6:0], din_lvl};
    wire       byte_end = sclk_fall && (bit_q == 3'h7);

    always @(posedge core_clk) begin
        if (!rst_n) begin
            state_q   <= ST_CMD;
            bit_q     <= 3'h0;
            sh_q      <= 8'h00;
            addr_q    <= 2'h0;
            left_q    <= 2'h0;
            tx_q      <= 8'h00;
            dout_q    <= 1'b0;
            dout_oe_q <= 1'b0;
            restart_q <= 1'b0;
            regs_q[0] <= `ACRB_RESET_VAL;
            regs_q[1] <= `ACRB_RESET_VAL;
            regs_q[2] <= `ACRB_RESET_VAL;
            regs_q[3] <= `ACRB_RESET_VAL;
        end else begin
            restart_q <= 1'b0;
            dout_oe_q <= cs_lvl;
            if (!cs_lvl) begin
                // Deselect aborts any partial command
                state_q <= ST_CMD;
                bit_q   <= 3'h0;
            end else begin
                if (sclk_rise && state_q == ST_RD) begin
                    dout_q <= tx_q[7];
                    tx_q   <= {tx_q[6:0], 1'b0};
                end
                if (sclk_fall) begin
                    sh_q  <= sh_next;
                    bit_q <= bit_q + 3'h1;
                end
                if (byte_end) begin
                    case (state_q)
                        ST_CMD: begin
                            addr_q <= sh_next[3:2];
                            left_q <= sh_next[1:0];
                            if (sh_next[7:4] == `ACRB_OP_WR) begin
                                state_q <= ST_WR;
                            end else if (sh_next[7:4] == `ACRB_OP_RD) begin
                                state_q <= ST_RD;
                                tx_q    <= regs_q[sh_next[3:2]];
                            end else begin
                                state_q <= ST_CMD;
                            end
                        end
                        ST_WR: begin
                            // Value lands on the final falling edge of each byte
                            regs_q[addr_q] <= sh_next;
                            addr_q         <= addr_q + 2'h1;
                            left_q         <= left_q - 2'h1;
                            if (left_q == 2'h0) begin
                                state_q   <= ST_CMD;
                                restart_q <= 1'b1;
                            end
                        end
                        ST_RD: begin
                            addr_q <= addr_q + 2'h1;
                            left_q <= left_q - 2'h1;
                            tx_q   <= regs_q[addr_q + 2'h1];
                            if (left_q == 2'h0) begin
                                state_q <= ST_CMD;
                            end
                        end
                        default: state_q <= ST_CMD;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field decode
    wire [3:0] in_sel = regs_q[0][`ACRB_IN_SEL_HI:`ACRB_IN_SEL_LO];
    wire [2:0] gsel   = regs_q[0][`ACRB_GAIN_HI:`ACRB_GAIN_LO];
    wire       byp    = regs_q[0][`ACRB_BYPASS_BIT];
    wire [2:0] rsel   = regs_q[1][`ACRB_RATE_HI:`ACRB_RATE_LO];
    wire [1:0] msel   = regs_q[1][`ACRB_MODE_HI:`ACRB_MODE_LO];
    wire       therm  = regs_q[1][`ACRB_THERM_BIT];

    // Input codes: 0 to 3 are pins, 4 is ground; 7 means not routed
    reg [2:0] pos_d;
    reg [2:0] neg_d;
    always @* begin
        case (in_sel)
            4'h0: begin pos_d = 3'h0; neg_d = 3'h1; end
            4'h1: begin pos_d = 3'h0; neg_d = 3'h2; end
            4'h2: begin pos_d = 3'h0; neg_d = 3'h3; end
            4'h3: begin pos_d = 3'h1; neg_d = 3'h2; end
            4'h4: begin pos_d = 3'h1; neg_d = 3'h3; end
            4'h5: begin pos_d = 3'h2; neg_d = 3'h3; end
            4'h6: begin pos_d = 3'h1; neg_d = 3'h0; end
            4'h7: begin pos_d = 3'h3; neg_d = 3'h2; end
            4'h8: begin pos_d = 3'h0; neg_d = 3'h4; end
            4'h9: begin pos_d = 3'h1; neg_d = 3'h4; end
            4'hA: begin pos_d = 3'h2; neg_d = 3'h4; end
            4'hB: begin pos_d = 3'h3; neg_d = 3'h4; end
            default: begin pos_d = 3'h7; neg_d = 3'h7; end
        endcase
    end

    // Thermal mode ignores the first register entirely
    wire       amp_on_d = therm | ~byp | (gsel > `ACRB_GAIN_MAX_BYP);
    wire       mon_d    = ~therm & (in_sel == `ACRB_IN_REF_MON);
    wire       rsvd_d   = (~therm & (in_sel == `ACRB_IN_RSVD)) |
                          (msel == 2'h3) | (rsel == `ACRB_RATE_RSVD);
    wire [31:0] rate_scaled = rate_nominal(msel, rsel) * CLK_KHZ / `ACRB_REF_CLK_KHZ;

    always @(posedge core_clk) begin
        if (!rst_n) begin
            pos_input_q          <= 3'h0;
            neg_input_q          <= 3'h1;
            ref_monitor_q        <= 1'b0;
            mid_short_q          <= 1'b0;
            gain_q               <= 8'h01;
            amp_enable_q         <= 1'b1;
            op_mode_q            <= `ACRB_MODE_NORMAL;
            continuous_q         <= 1'b0;
            thermal_sense_q      <= 1'b0;
            fault_current_q      <= 1'b0;
            rate_centi_sps_q     <= 16'h07D0;
            config_fault_q       <= 1'b0;
            ref_select_q         <= 2'h0;
            filter_select_q      <= 2'h0;
            low_side_switch_q    <= 1'b0;
            excitation_current_q <= 3'h0;
        end else begin
            pos_input_q      <= therm ? 3'h7 : pos_d;
            neg_input_q      <= therm ? 3'h7 : neg_d;
            ref_monitor_q    <= mon_d;
            mid_short_q      <= ~therm & (in_sel == 4'hD);
            gain_q           <= therm ? 8'h01 : (8'h01 << gsel);
            // Monitor code bypasses the amplifier regardless of the bit
            amp_enable_q     <= amp_on_d & ~mon_d;
            op_mode_q        <= msel;
            continuous_q     <= regs_q[1][`ACRB_CONT_BIT];
            thermal_sense_q  <= therm;
            fault_current_q  <= regs_q[1][`ACRB_FAULT_BIT];
            rate_centi_sps_q <= rate_scaled[15:0];
            config_fault_q   <= rsvd_d | (~therm & (in_sel >= `ACRB_IN_GND_MIN)
                                 & (in_sel < `ACRB_IN_REF_MON) & amp_on_d);
            ref_select_q         <= regs_q[2][`ACRB_REF_HI:`ACRB_REF_LO];
            filter_select_q      <= regs_q[2][`ACRB_FILT_HI:`ACRB_FILT_LO];
            low_side_switch_q    <= regs_q[2][`ACRB_SW_BIT];
            excitation_current_q <= regs_q[2][`ACRB_EXC_HI:`ACRB_EXC_LO];
        end
    end
endmodule // acrb_config_bank

//--- verilog/acrb_regs.vh
`ifndef ACRB_REGS_VH
`define ACRB_REGS_VH
// Register indices (two-bit address from the command byte)
`define ACRB_IDX_INPUT_GAIN   2'h0
`define ACRB_IDX_RATE_MODE    2'h1
`define ACRB_IDX_REF_FILT     2'h2
`define ACRB_IDX_SPARE        2'h3
`define ACRB_RESET_VAL        8'h00
// Command opcodes (upper nibble)
`define ACRB_OP_RD            4'h2
`define ACRB_OP_WR            4'h4
// First register fields
`define ACRB_IN_SEL_HI        7
`define ACRB_IN_SEL_LO        4
`define ACRB_GAIN_HI          3
`define ACRB_GAIN_LO          1
`define ACRB_BYPASS_BIT       0
// Second register fields
`define ACRB_RATE_HI          7
`define ACRB_RATE_LO          5
`define ACRB_MODE_HI          4
`define ACRB_MODE_LO          3
`define ACRB_CONT_BIT         2
`define ACRB_THERM_BIT        1
`define ACRB_FAULT_BIT        0
// Third register fields
`define ACRB_REF_HI           7
`define ACRB_REF_LO           6
`define ACRB_FILT_HI          5
`define ACRB_FILT_LO          4
`define ACRB_SW_BIT           3
`define ACRB_EXC_HI           2
`define ACRB_EXC_LO           0
// Codes
`define ACRB_IN_GND_MIN       4'h8
`define ACRB_IN_REF_MON       4'hC
`define ACRB_IN_RSVD          4'hF
`define ACRB_GAIN_MAX_BYP     3'h2
`define ACRB_MODE_NORMAL      2'h0
`define ACRB_MODE_DUTY        2'h1
`define ACRB_MODE_TURBO       2'h2
`define ACRB_RATE_RSVD        3'h7
`define ACRB_REF_CLK_KHZ      4096
`endif

//--- verilog/acrb_serial_sync.v
`timescale 1ns/100ps
// Three-stage synchroniser; change accepted when stages two and three agree
module acrb_serial_sync (
    // Clock and reset
    input  wire core_clk,
    input  wire rst_n,
    // Pin side
    input  wire pin_in,
    // Core side
    output reg  level_q,
    output reg  rise_q,
    output reg  fall_q
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    always @(posedge core_clk) begin
        if (!rst_n) begin
            s1_q    <= 1'b0;
            s2_q    <= 1'b0;
            s3_q    <= 1'b0;
            level_q <= 1'b0;
            rise_q  <= 1'b0;
            fall_q  <= 1'b0;
        end else begin
            s1_q   <= pin_in;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
            if (s2_q == s3_q && s3_q != level_q) begin
                level_q <= s3_q;
                rise_q  <= s3_q;
                fall_q  <= ~s3_q;
            end
        end
    end
endmodule // acrb_serial_sync
